//--- rtl/smem_consts.svh
/*
  constants for the static memory controller: reset values, slow clock
  waveform, page geometry. assumes inclusion by the core.
*/
`ifndef SMEM_CONSTS_SVH
`define SMEM_CONSTS_SVH
`define SMEM_SLOW_SETUP 9'h001
`define SMEM_SLOW_PULSE 9'h001
`define SMEM_SLOW_CYCLE 9'h003
`define SMEM_PAGE_MIN_BYTES 6'h04
`define SMEM_CS_IDLE 4'hf
`define SMEM_ADDR_RESET 24'h000000
`define SMEM_DATA_RESET 8'h00
`define SMEM_WORD_RESET 32'h00000000
`define SMEM_FLOAT_RESET 4'h0
`endif

//--- rtl/smem_pkg.sv
/*
  types shared by the static memory controller core and its users.
  assumes smem_consts.svh sits beside it.
*/
package smem_pkg;
    // size: 0 byte, 1 halfword, 2 word
    typedef struct packed {
        logic valid;
        logic write;
        logic [1:0] size;
        logic [1:0] cs;
        logic [23:0] addr;
        logic [31:0] wdata;
    } smem_req_t;

    typedef struct packed {
        logic [5:0] rd_setup;
        logic [6:0] rd_pulse;
        logic [5:0] cs_rd_setup;
        logic [6:0] cs_rd_pulse;
        logic [8:0] rd_cycle;
        logic [5:0] wr_setup;
        logic [6:0] wr_pulse;
        logic [5:0] cs_wr_setup;
        logic [6:0] cs_wr_pulse;
        logic [8:0] wr_cycle;
        logic read_mode;
        logic write_mode;
        logic [3:0] float_cycles;
        logic page_mode;
        logic [1:0] page_size;
        logic [6:0] page_pulse;
    } smem_cfg_t;

    typedef struct packed {
        logic [8:0] st_setup;
        logic [8:0] st_pulse;
        logic [8:0] cs_setup;
        logic [8:0] cs_pulse;
        logic [8:0] cycle;
    } smem_wave_t;

    typedef enum logic {S_IDLE, S_ACCESS} smem_state_t;
endpackage

//--- rtl/smem_ctrl.sv
/*
  static memory controller core: turns one request into byte accesses with
  programmable waveforms, wait stretching, slow and page modes, flash routing
  and scrambling. assumes config is stable while an access runs and the
  external tristate buffer is resolved outside from data_oe_n.
*/
`timescale 1ns/1ps
`include "smem_consts.svh"
module smem_ctrl #(
    parameter int NUM_CS = 4
)(
    input wire logic clk,
    input wire logic reset,
    input wire smem_pkg::smem_req_t req,
    output logic req_ready,
    output logic done,
    output logic [31:0] rdata,
    input wire smem_pkg::smem_cfg_t [3:0] cs_cfg,
    input wire logic [3:0] nand_assign,
    input wire logic slow_clock_mode,
    input wire logic scramble_en,
    input wire logic [31:0] key0,
    input wire logic [31:0] key1,
    input wire logic wait_request_n,
    input wire logic [7:0] data_in,
    output logic [7:0] data_out,
    output logic data_oe_n,
    output logic [23:0] address,
    output logic [3:0] chip_select_lines_n,
    output logic read_strobe_n,
    output logic write_strobe_n,
    output logic flash_chip_select_n,
    output logic flash_output_enable_n,
    output logic flash_write_enable_n
);
    smem_pkg::smem_state_t state, next_state;
    logic [8:0] cnt, next_cnt;
    logic [1:0] idx, next_idx, last, next_last, cs, next_cs;
    logic wr, next_wr, page, next_page;
    logic [23:0] base, next_base, next_address;
    logic [31:0] wdata, next_wdata, rbuf, next_rbuf, next_rdata;
    logic [3:0] float_cnt, next_float_cnt, next_cs_n;
    logic next_done, next_ready, fin, stall, sample;
    logic next_rd_n, next_wr_n, next_fcs_n, next_foe_n, next_fwe_n, next_oe_n;
    logic [7:0] next_dout;
    logic st_low, cs_low, is_nand, act;
    logic [8:0] ctrl_setup, ctrl_pulse;
    smem_pkg::smem_wave_t cw, nw;
    logic w1, w2, w3, wait_act;

    function automatic smem_pkg::smem_wave_t wave_of(smem_pkg::smem_cfg_t c, logic w,
                                                      logic slow, logic pg);
        smem_pkg::smem_wave_t v;
        v.st_setup = w ? {3'h0, c.wr_setup} : {3'h0, c.rd_setup};
        v.st_pulse = w ? {2'h0, c.wr_pulse} : {2'h0, c.rd_pulse};
        v.cs_setup = w ? {3'h0, c.cs_wr_setup} : {3'h0, c.cs_rd_setup};
        v.cs_pulse = w ? {2'h0, c.cs_wr_pulse} : {2'h0, c.cs_rd_pulse};
        // hold is what the cycle leaves
        v.cycle = w ? c.wr_cycle : c.rd_cycle;
        if (slow)
        begin
            v.st_setup = `SMEM_SLOW_SETUP;
            v.st_pulse = `SMEM_SLOW_PULSE;
            v.cs_setup = `SMEM_SLOW_SETUP;
            v.cs_pulse = `SMEM_SLOW_PULSE;
            v.cycle = `SMEM_SLOW_CYCLE;
        end
        else if (pg)
        begin
            v.st_setup = 9'h000;
            v.cs_setup = 9'h000;
            v.st_pulse = {2'h0, c.page_pulse};
            v.cs_pulse = {2'h0, c.page_pulse};
            v.cycle = {2'h0, c.page_pulse};
        end
        return v;
    endfunction

    function automatic logic in_pulse(logic [8:0] n, logic [8:0] s, logic [8:0] p);
        return (n >= s) && (n < 9'(s + p));
    endfunction

    // xor scrambling, same function both ways
    function automatic logic [7:0] scr(logic [7:0] b, logic [23:0] a, logic en,
                                       logic [31:0] k0, logic [31:0] k1);
        return en ? (b ^ k0[{a[1:0], 3'h0} +: 8] ^ k1[{a[3:2], 3'h0} +: 8]) : b;
    endfunction

    // wait pin: three stages, change taken when stages two and three agree
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            w1 <= 1'b1;
            w2 <= 1'b1;
            w3 <= 1'b1;
            wait_act <= 1'b0;
        end
        else
        begin
            w1 <= wait_request_n;
            w2 <= w1;
            w3 <= w2;
            if (w2 == w3)
                wait_act <= ~w3;
        end
    end

    always_comb
    begin
        next_state = state;
        next_cnt = cnt;
        next_idx = idx;
        next_last = last;
        next_cs = cs;
        next_wr = wr;
        next_page = page;
        next_base = base;
        next_wdata = wdata;
        next_rbuf = rbuf;
        next_rdata = rdata;
        next_done = 1'b0;
        fin = 1'b0;
        next_float_cnt = (float_cnt != 4'h0) ? 4'(float_cnt - 4'h1) : float_cnt;
        cw = wave_of(cs_cfg[cs], wr, slow_clock_mode, page);
        ctrl_setup = ((wr ? cs_cfg[cs].write_mode : cs_cfg[cs].read_mode) != 1'b0)
                     ? cw.st_setup : cw.cs_setup;
        ctrl_pulse = ((wr ? cs_cfg[cs].write_mode : cs_cfg[cs].read_mode) != 1'b0)
                     ? cw.st_pulse : cw.cs_pulse;
        // freeze the count while the device holds wait inside the controlling pulse
        stall = (state == smem_pkg::S_ACCESS) && wait_act && in_pulse(cnt, ctrl_setup, ctrl_pulse);
        // sample on the edge ending the controlling pulse
        sample = (state == smem_pkg::S_ACCESS) && !wr && !stall
                 && (9'(cnt + 9'h001) == 9'(ctrl_setup + ctrl_pulse));
        if (sample)
            next_rbuf[{idx, 3'h0} +: 8] = scr(data_in, 24'(base + {22'h0, idx}), scramble_en,
                                              key0, key1);
        case (state)
            smem_pkg::S_IDLE:
            begin
                // no write drive until float time has passed
                if (req.valid && (!req.write || float_cnt == 4'h0))
                begin
                    // selects beyond the build count complete empty
                    if (32'(req.cs) >= NUM_CS)
                    begin
                        next_done = 1'b1;
                        next_rdata = `SMEM_WORD_RESET;
                    end
                    else
                    begin
                        next_state = smem_pkg::S_ACCESS;
                        next_cnt = 9'h000;
                        next_idx = 2'h0;
                        next_last = (req.size == 2'h0) ? 2'h0 : (req.size == 2'h1) ? 2'h1 : 2'h3;
                        next_cs = req.cs;
                        next_wr = req.write;
                        next_page = 1'b0;
                        next_base = req.addr;
                        next_wdata = req.wdata;
                        next_rbuf = `SMEM_WORD_RESET;
                    end
                end
            end
            smem_pkg::S_ACCESS:
            begin
                if (!stall)
                begin
                    if (9'(cnt + 9'h001) >= cw.cycle)
                    begin
                        next_cnt = 9'h000;
                        if (idx == last)
                        begin
                            fin = 1'b1;
                            next_state = smem_pkg::S_IDLE;
                            next_done = 1'b1;
                            if (!wr)
                                next_float_cnt = cs_cfg[cs].float_cycles;
                        end
                        else
                        begin
                            next_idx = 2'(idx + 2'h1);
                            next_page = cs_cfg[cs].page_mode && !wr
                                && ((6'(base[5:0] + {4'h0, next_idx})
                                     & 6'((`SMEM_PAGE_MIN_BYTES << cs_cfg[cs].page_size) - 6'h1))
                                    != 6'h00);
                        end
                    end
                    else
                        next_cnt = 9'(cnt + 9'h001);
                end
            end
            default:
                next_state = smem_pkg::S_IDLE;
        endcase
        if (fin)
            next_rdata = next_rbuf;
        // pins follow the next count, idle is all high
        act = next_state == smem_pkg::S_ACCESS;
        nw = wave_of(cs_cfg[next_cs], next_wr, slow_clock_mode, next_page);
        st_low = act && in_pulse(next_cnt, nw.st_setup, nw.st_pulse);
        cs_low = act && in_pulse(next_cnt, nw.cs_setup, nw.cs_pulse);
        is_nand = nand_assign[next_cs];
        next_rd_n = !(st_low && !next_wr && !is_nand);
        next_wr_n = !(st_low && next_wr && !is_nand);
        next_foe_n = !(st_low && !next_wr && is_nand);
        next_fwe_n = !(st_low && next_wr && is_nand);
        next_fcs_n = !(cs_low && is_nand);
        next_oe_n = !(act && next_wr && next_cnt >=
            ((cs_cfg[next_cs].write_mode != 1'b0) ? nw.st_setup : nw.cs_setup));
        next_address = act ? 24'(next_base + {22'h0, next_idx}) : address;
        next_dout = act && next_wr
            ? scr(next_wdata[{next_idx, 3'h0} +: 8], next_address, scramble_en, key0, key1)
            : data_out;
        next_ready = !act;
    end

    // each select line only while its own access runs
    genvar g;
    generate
        for (g = 0; g < 4; g++)
        begin : g_cs
            if (g < NUM_CS)
            begin : g_on
                assign next_cs_n[g] = !(cs_low && next_cs == 2'(g));
            end
            else
            begin : g_off
                assign next_cs_n[g] = 1'b1;
            end
        end
    endgenerate

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            state <= smem_pkg::S_IDLE;
            cnt <= 9'h000;
            idx <= 2'h0;
            last <= 2'h0;
            cs <= 2'h0;
            wr <= 1'b0;
            page <= 1'b0;
            base <= `SMEM_ADDR_RESET;
            wdata <= `SMEM_WORD_RESET;
            rbuf <= `SMEM_WORD_RESET;
            rdata <= `SMEM_WORD_RESET;
            float_cnt <= `SMEM_FLOAT_RESET;
            done <= 1'b0;
            req_ready <= 1'b1;
            address <= `SMEM_ADDR_RESET;
            data_out <= `SMEM_DATA_RESET;
            data_oe_n <= 1'b1;
            chip_select_lines_n <= `SMEM_CS_IDLE;
            read_strobe_n <= 1'b1;
            write_strobe_n <= 1'b1;
            flash_chip_select_n <= 1'b1;
            flash_output_enable_n <= 1'b1;
            flash_write_enable_n <= 1'b1;
        end
        else
        begin
            state <= next_state;
            cnt <= next_cnt;
            idx <= next_idx;
            last <= next_last;
            cs <= next_cs;
            wr <= next_wr;
            page <= next_page;
            base <= next_base;
            wdata <= next_wdata;
            rbuf <= next_rbuf;
            rdata <= next_rdata;
            float_cnt <= next_float_cnt;
            done <= next_done;
            req_ready <= next_ready;
            address <= next_address;
            data_out <= next_dout;
            data_oe_n <= next_oe_n;
            chip_select_lines_n <= next_cs_n;
            read_strobe_n <= next_rd_n;
            write_strobe_n <= next_wr_n;
            flash_chip_select_n <= next_fcs_n;
            flash_output_enable_n <= next_foe_n;
            flash_write_enable_n <= next_fwe_n;
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);

    a_cs_single: assert property ($onehot0(~chip_select_lines_n))
        else $error("more than one chip select low");
    a_idle_pins_high: assert property (req_ready |-> (chip_select_lines_n == `SMEM_CS_IDLE)
        && read_strobe_n && write_strobe_n && flash_output_enable_n)
        else $error("control pin low while idle");
    a_wait_freeze: assert property (stall |=> (cnt == $past(cnt)) && (state == smem_pkg::S_ACCESS))
        else $error("count moved during wait");
    a_slow_cycle_end: assert property ((state == smem_pkg::S_ACCESS) && slow_clock_mode && !stall
        && (9'(cnt + 9'h001) >= `SMEM_SLOW_CYCLE) |=> (cnt == 9'h000))
        else $error("slow cycle overran");
    a_flash_route: assert property (!flash_output_enable_n |-> read_strobe_n
        && nand_assign[cs] && !wr)
        else $error("flash read enable without assigned select");
    a_flash_window: assert property (!flash_write_enable_n |-> (state == smem_pkg::S_ACCESS)
        && nand_assign[cs] && write_strobe_n)
        else $error("flash write enable outside its window");
    a_float_quiet: assert property ((float_cnt != 4'h0) |-> data_oe_n)
        else $error("bus driven within float time");
    a_byte_step: assert property ((state == smem_pkg::S_ACCESS) && $past(state == smem_pkg::S_ACCESS)
        && (idx != $past(idx)) |-> address == 24'($past(address) + 24'h000001))
        else $error("byte address not incremented");
    a_strobe_excl: assert property (!(!read_strobe_n && !write_strobe_n))
        else $error("read and write strobes both low");

    c_word_write: cover property (req.valid && req.write && req.size == 2'h2 && req_ready
        ##[1:300] done);
    c_wait_stretch: cover property (stall [*3]);
    c_page_read: cover property (page && !read_strobe_n);
    c_flash_cmd: cover property (!flash_write_enable_n && address[22]);
endmodule // smem_ctrl

//--- bench/smem_mem_model.sv
/*
  far-side byte memory for the static memory controller bench.
  assumes it sits directly on the controller pins and shares its clock.
*/
`timescale 1ns/1ps
module smem_mem_model (
    input wire logic clk,
    input wire logic slow,
    input wire logic [23:0] address,
    input wire logic [3:0] cs_n,
    input wire logic rd_n,
    input wire logic wr_n,
    input wire logic foe_n,
    input wire logic fwe_n,
    input wire logic [7:0] dout,
    input wire logic doe_n,
    output logic [7:0] din,
    output logic wait_n
);
    logic [7:0] mem [256];
    logic [7:0] last = 8'h00;
    logic [3:0] wcnt = 4'h0;
    logic rd_q = 1'b1;
    // the write pin idles high, so flash writes pass through the and
    wire we_n = wr_n & fwe_n;
    // system line holds the flash enable low between accesses
    wire flash_ce_n = 1'b0;
    wire drive = ((cs_n != 4'hf) || (!flash_ce_n && !foe_n)) && doe_n;
    assign wait_n = (wcnt == 4'h0);
    // no pull on the data lines, so a released bus shows the inverse of the last byte
    assign din = drive ? mem[address[7:0]] : ~last;
    always @(posedge we_n)
    begin
        if (!doe_n)
            mem[address[7:0]] = dout;
    end
    always @(posedge clk)
    begin
        if (drive)
            last <= mem[address[7:0]];
        rd_q <= rd_n & foe_n;
        if (slow && rd_q && !(rd_n & foe_n))
            wcnt <= 4'h6;
        else if (wcnt != 4'h0)
            wcnt <= wcnt - 4'h1;
    end
endmodule // smem_mem_model

//--- bench/static_memory_controller_tb_top.sv
/*
  self-checking bench for smem_ctrl: byte, word, wait, slow, flash and
  scrambled accesses against a byte memory. assumes a 50 MHz clock.
*/
`timescale 1ns/1ps
module static_memory_controller_tb_top;
    logic clk = 1'b0;
    logic reset = 1'b1;
    smem_pkg::smem_req_t req = '0;
    smem_pkg::smem_cfg_t [3:0] cfg;
    logic [3:0] nand_assign = 4'h0;
    logic slow_clock_mode = 1'b0;
    logic scramble_en = 1'b0;
    logic [31:0] key0 = 32'h11223344;
    logic [31:0] key1 = 32'h55667788;
    logic slow = 1'b0;
    logic req_ready, done, data_oe_n, read_strobe_n, write_strobe_n, wait_request_n;
    logic flash_chip_select_n, flash_output_enable_n, flash_write_enable_n;
    logic [31:0] rdata, got;
    logic [7:0] data_in, data_out;
    logic [23:0] address;
    logic [3:0] cs_n;
    int miscompares = 0;
    int tests_run = 0;
    int cycles = 0;
    int lat, take_n, rd_low, wr_low, fo_low, fw_low;
    int cs_low [4];

    smem_ctrl #(.NUM_CS(4)) dut (.clk(clk), .reset(reset), .req(req), .req_ready(req_ready),
        .done(done), .rdata(rdata), .cs_cfg(cfg), .nand_assign(nand_assign),
        .slow_clock_mode(slow_clock_mode), .scramble_en(scramble_en), .key0(key0),
        .key1(key1), .wait_request_n(wait_request_n), .data_in(data_in),
        .data_out(data_out), .data_oe_n(data_oe_n), .address(address),
        .chip_select_lines_n(cs_n), .read_strobe_n(read_strobe_n),
        .write_strobe_n(write_strobe_n), .flash_chip_select_n(flash_chip_select_n),
        .flash_output_enable_n(flash_output_enable_n),
        .flash_write_enable_n(flash_write_enable_n));

    smem_mem_model u_mem (.clk(clk), .slow(slow), .address(address), .cs_n(cs_n),
        .rd_n(read_strobe_n), .wr_n(write_strobe_n), .foe_n(flash_output_enable_n),
        .fwe_n(flash_write_enable_n), .dout(data_out), .doe_n(data_oe_n),
        .din(data_in), .wait_n(wait_request_n));

    initial
    begin
        forever #10 clk = ~clk;
    end

    // low-cycle counters per pin, cleared by the access task
    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        rd_low <= rd_low + int'(!read_strobe_n);
        wr_low <= wr_low + int'(!write_strobe_n);
        fo_low <= fo_low + int'(!flash_output_enable_n);
        fw_low <= fw_low + int'(!flash_write_enable_n);
        for (int i = 0; i < 4; i++)
            cs_low[i] <= cs_low[i] + int'(!cs_n[i]);
        if (cycles == 20000)
        begin
            miscompares = miscompares + 1;
            end_of_test();
        end
    end

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] seen);
        tests_run++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // setup 1 and hold 1 on the strobes keep them off the null-delay path
    function automatic smem_pkg::smem_cfg_t mk(input logic [6:0] p, input logic rm);
        smem_pkg::smem_cfg_t c;
        c = '0;
        c.rd_setup = 6'h01;
        c.rd_pulse = p;
        c.cs_rd_pulse = p + 7'h02;
        c.rd_cycle = {2'h0, p} + 9'h002;
        c.wr_setup = 6'h01;
        c.wr_pulse = p;
        c.cs_wr_pulse = p + 7'h02;
        c.wr_cycle = {2'h0, p} + 9'h002;
        c.read_mode = rm;
        c.write_mode = 1'b1;
        c.page_pulse = 7'h01;
        return c;
    endfunction

    task automatic acc(input logic w, input logic [1:0] sz, input logic [1:0] cs,
                       input logic [23:0] a, input logic [31:0] wd);
        take_n = 0;
        @(posedge clk);
        #2;
        while (req_ready !== 1'b1 && take_n < 100)
        begin
            @(posedge clk);
            #2;
            take_n++;
        end
        // a write may sit out the float time with ready still high, so valid is held
        req = {1'b1, w, sz, cs, a, wd};
        do
        begin
            @(posedge clk);
            #2;
            take_n++;
        end
        while (req_ready === 1'b1 && done !== 1'b1 && take_n < 200);
        req.valid = 1'b0;
        rd_low = 0;
        wr_low = 0;
        fo_low = 0;
        fw_low = 0;
        cs_low = '{0, 0, 0, 0};
        lat = 0;
        while (done !== 1'b1 && lat < 400)
        begin
            @(posedge clk);
            #2;
            lat++;
        end
        got = rdata;
        chk("done", 32'h1, {31'h0, done});
        repeat (2) @(posedge clk);
        #2;
    endtask

    initial
    begin
        // every pulse programmed to one or more
        for (int i = 0; i < 4; i++)
            cfg[i] = mk(7'h02, 1'b1);
        repeat (8) @(posedge clk);
        #2;
        chk("idle pins", 32'h000007ff, {cs_n, read_strobe_n, write_strobe_n, flash_chip_select_n,
            flash_output_enable_n, flash_write_enable_n, data_oe_n, req_ready});
        chk("idle address", 32'h0, {8'h00, address});
        reset = 1'b0;
        acc(1'b1, 2'h0, 2'h0, 24'h000010, 32'h000000a5);
        chk("write pulse", 2, wr_low);
        chk("mem byte", 32'ha5, {24'h0, u_mem.mem[8'h10]});
        acc(1'b0, 2'h0, 2'h0, 24'h000010, 32'h0);
        chk("read byte", 32'ha5, {24'h0, got[7:0]});
        chk("read latency", 4, lat);
        chk("read pulse", 2, rd_low);
        chk("cs0 low", 4, cs_low[0]);
        $display("test byte done");
        acc(1'b1, 2'h2, 2'h1, 24'hffffff, 32'h44332211);
        for (int k = 0; k < 4; k++)
            chk("word byte", (32'h44332211 >> (8 * k)) & 32'hff,
                {24'h0, u_mem.mem[8'(8'hff + k)]});
        acc(1'b0, 2'h2, 2'h1, 24'hffffff, 32'h0);
        chk("word read", 32'h44332211, got);
        chk("word latency", 16, lat);
        chk("word cs", 16, cs_low[1] + 100 * cs_low[0]);
        $display("test word done");
        for (int c = 2; c < 4; c++)
        begin
            cfg[c] = mk(7'h02, 1'b0);
            acc(1'b1, 2'h0, 2'(c), 24'h800030 + 24'(c), 32'(8'h60 + c));
            acc(1'b0, 2'h0, 2'(c), 24'h800030 + 24'(c), 32'h0);
            chk("cs read", 32'(8'h60 + c), {24'h0, got[7:0]});
            chk("own cs", 4, cs_low[c]);
            chk("other cs", 0, cs_low[0] + cs_low[1] + cs_low[2] + cs_low[3] - cs_low[c]);
        end
        $display("test selects done");
        cfg[1].page_mode = 1'b1;
        acc(1'b1, 2'h2, 2'h1, 24'h000020, 32'hd4c3b2a1);
        acc(1'b0, 2'h2, 2'h1, 24'h000020, 32'h0);
        chk("page read", 32'hd4c3b2a1, got);
        chk("page latency", 7, lat);
        cfg[1].page_mode = 1'b0;
        $display("test page done");
        nand_assign = 4'h2;
        acc(1'b1, 2'h0, 2'h1, 24'h400000, 32'h00000090);
        chk("flash wr", 32'h00000002, {wr_low[15:0], fw_low[15:0]});
        acc(1'b0, 2'h0, 2'h1, 24'h200000, 32'h0);
        chk("flash rd", 32'h90, {24'h0, got[7:0]});
        chk("flash oe", 32'h00000002, {rd_low[15:0], fo_low[15:0]});
        cfg[2].float_cycles = 4'hf;
        acc(1'b0, 2'h0, 2'h2, 24'h800032, 32'h0);
        chk("non flash", 32'h00020000, {rd_low[15:0], fo_low[15:0] + fw_low[15:0]});
        acc(1'b1, 2'h0, 2'h2, 24'h800034, 32'h00000077);
        chk("float hold", 13, take_n);
        nand_assign = 4'h0;
        $display("test flash done");
        cfg[0] = mk(7'h06, 1'b1);
        slow = 1'b1;
        acc(1'b0, 2'h0, 2'h0, 24'h000010, 32'h0);
        chk("wait data", 32'ha5, {24'h0, got[7:0]});
        chk("wait stretch", 1, rd_low > 6);
        slow = 1'b0;
        slow_clock_mode = 1'b1;
        acc(1'b0, 2'h0, 2'h0, 24'h000010, 32'h0);
        chk("slow pulse", 1, rd_low);
        chk("slow latency", 3, lat);
        slow_clock_mode = 1'b0;
        $display("test wait and slow done");
        scramble_en = 1'b1;
        acc(1'b1, 2'h0, 2'h0, 24'h000041, 32'h0000005a);
        chk("scrambled mem", 32'he1, {24'h0, u_mem.mem[8'h41]});
        acc(1'b0, 2'h0, 2'h0, 24'h000041, 32'h0);
        chk("unscrambled", 32'h5a, {24'h0, got[7:0]});
        $display("test scramble done");
        end_of_test();
    end
endmodule // static_memory_controller_tb_top
